// file: crpc_codec_reset_power_control.sv
// reset, start-up lockout, pll settle and output-stage reset logic with its control bus slave
//
// Overview of operation
// - answer on the control bus at address 0011000, never act as master
// - registers are eight bits, writable ones read back their stored value
// - register pointer advances after each byte; fast bus speed supported
// - reset pin low at least 10 ns returns all logic except the coefficient buffer contents to defaults
// - writing one to page 0 register 1 bit 0 resets the device
// - after any reset, memories initialise within 1 ms
// - codec clocks wait about 10 ms after pll power-up
// - each of four stages has its own overcurrent re-enable reset bit
// - page 1 register 31 bits 7 and 6 reset left and right headphone stages
// - page 1 register 32 bits 7 and 6 reset left and right speaker pairs
// - after reset all blocks are powered down until written on
// - powering a block down keeps every register setting
`timescale 1ns/1ps
`default_nettype none
module crpc_codec_reset_power_control #(
  parameter int INIT_COUNT = crpc_pkg::INIT_CYCLES,
  parameter int PLL_COUNT  = crpc_pkg::PLL_CYCLES,
  parameter int COEF_DEPTH = 16
) (
  // clock and resets
  input  wire logic                             core_clk,
  input  wire logic                             reset,
  input  wire logic                             resetPinN,
  // control bus pins, open drain data
  input  wire logic                             scl,
  input  wire logic                             sdaIn,
  output logic                                  sdaOut,
  output logic                                  sdaOe,
  // output stage faults and enables
  input  wire logic [crpc_pkg::NUM_STAGES-1:0]  overcurrent,
  output logic      [crpc_pkg::NUM_STAGES-1:0]  stageEnable,
  // clocking and start-up status
  output logic                                  pllPowerOn,
  output logic                                  codecClkEnable,
  output logic                                  initBusy
);
  import crpc_pkg::*;

  localparam logic [CNT_W-1:0] INIT_LAST = CNT_W'(INIT_COUNT - 1);
  localparam logic [CNT_W-1:0] PLL_LAST  = CNT_W'(PLL_COUNT - 1);

  // pin reset acts asynchronously so a 10 ns pulse is never missed
  logic rstAll;
  assign rstAll = reset | ~resetPinN;

  // pin synchronisers and filtered levels
  logic [2:0] sclSync_ff;
  logic [2:0] sdaSync_ff;
  logic       sclF_ff;
  logic       sdaF_ff;
  logic       nxt_sclF;
  logic       nxt_sdaF;
  logic       sclRise;
  logic       sclFall;
  logic       busStart;
  logic       busStop;

  // bus slave state
  crpc_bus_state_t busState_ff;
  crpc_bus_state_t nxt_busState;
  logic [3:0]      bitCnt_ff;
  logic [3:0]      nxt_bitCnt;
  logic [7:0]      shift_ff;
  logic [7:0]      nxt_shift;
  logic [7:0]      ptr_ff;
  logic [7:0]      nxt_ptr;
  logic            rwBit_ff;
  logic            nxt_rwBit;
  logic            sdaOe_ff;
  logic            nxt_sdaOe;
  logic            wrEn;
  logic [7:0]      rdData;

  // control state
  logic [7:0]            page_ff;
  logic [7:0]            nxt_page;
  logic [7:0]            power_ff;
  logic [7:0]            nxt_power;
  logic [7:0]            coefMem_ff [COEF_DEPTH];
  logic [NUM_STAGES-1:0] latched_ff;
  logic [NUM_STAGES-1:0] nxt_latched;
  logic [NUM_STAGES-1:0] stageRst;
  logic [NUM_STAGES-1:0] stageEn_ff;
  logic [NUM_STAGES-1:0] nxt_stageEn;
  logic [CNT_W-1:0]      initCnt_ff;
  logic [CNT_W-1:0]      nxt_initCnt;
  logic                  initBusy_ff;
  logic                  nxt_initBusy;
  logic [CNT_W-1:0]      pllCnt_ff;
  logic [CNT_W-1:0]      nxt_pllCnt;
  logic                  clkReady_ff;
  logic                  nxt_clkReady;
  logic                  softRst;
  logic                  coefOk;

  // a filtered level moves only when the second and third stages agree
  always_comb begin
    nxt_sclF = (sclSync_ff[1] == sclSync_ff[2]) ? sclSync_ff[2] : sclF_ff;
    nxt_sdaF = (sdaSync_ff[1] == sdaSync_ff[2]) ? sdaSync_ff[2] : sdaF_ff;
    sclRise  = nxt_sclF & ~sclF_ff;
    sclFall  = ~nxt_sclF & sclF_ff;
    busStart = sclF_ff & nxt_sclF & sdaF_ff & ~nxt_sdaF;
    busStop  = sclF_ff & nxt_sclF & ~sdaF_ff & nxt_sdaF;
  end

  always_ff @(posedge core_clk or posedge rstAll) begin
    if (rstAll) begin
      sclSync_ff <= 3'h7;
      sdaSync_ff <= 3'h7;
      sclF_ff    <= 1'b1;
      sdaF_ff    <= 1'b1;
    end else begin
      sclSync_ff <= {sclSync_ff[1:0], scl};
      sdaSync_ff <= {sdaSync_ff[1:0], sdaIn};
      sclF_ff    <= nxt_sclF;
      sdaF_ff    <= nxt_sdaF;
    end
  end

  // coefficient buffer reachable only once initialisation is over
  // coefficient access gate
  assign coefOk = (page_ff == PAGE_COEF) && (ptr_ff < 8'(COEF_DEPTH)) && !initBusy_ff;

  // register read mux; self-clearing reset bits always read zero
  // reset bits read zero
  always_comb begin
    rdData = 8'h00;
    if (ptr_ff == PAGE_SEL_OFF) begin
      rdData = page_ff;
    end else if (page_ff == PAGE_CTRL && ptr_ff == STATUS_OFF) begin
      rdData = {clkReady_ff, initBusy_ff, 2'b00, latched_ff};
    end else if (page_ff == PAGE_CTRL && ptr_ff == POWER_CTRL_OFF) begin
      rdData = power_ff;
    end else if (coefOk) begin
      rdData = coefMem_ff[ptr_ff[$clog2(COEF_DEPTH)-1:0]];
    end
  end

  // control bus slave: sample on scl rise, drive on scl fall
  always_comb begin
    nxt_busState = busState_ff;
    nxt_bitCnt   = bitCnt_ff;
    nxt_shift    = shift_ff;
    nxt_ptr      = ptr_ff;
    nxt_rwBit    = rwBit_ff;
    nxt_sdaOe    = sdaOe_ff;
    wrEn         = 1'b0;
    if (busStop) begin
      nxt_busState = BUS_IDLE;
      nxt_sdaOe    = 1'b0;
    end else if (busStart) begin
      nxt_busState = BUS_ADDR;
      nxt_bitCnt   = 4'h0;
      nxt_sdaOe    = 1'b0;
    end else begin
      case (busState_ff)
        BUS_ADDR, BUS_WREG, BUS_WDATA: begin
          if (sclRise) begin
            nxt_shift  = {shift_ff[6:0], sdaF_ff};
            nxt_bitCnt = bitCnt_ff + 4'h1;
          end else if (sclFall && bitCnt_ff == 4'h8) begin
            nxt_bitCnt = 4'h0;
            nxt_sdaOe  = 1'b1;
            if (busState_ff == BUS_ADDR) begin
              // fixed slave address, only ever answers
              if (shift_ff[7:1] == SLAVE_ADDR) begin
                nxt_rwBit    = shift_ff[0];
                nxt_busState = BUS_ACK_ADDR;
              end else begin
                nxt_sdaOe    = 1'b0;
                nxt_busState = BUS_IDLE;
              end
            end else if (busState_ff == BUS_WREG) begin
              nxt_ptr      = shift_ff;
              nxt_busState = BUS_ACK_REG;
            end else begin
              // pointer advances after each written byte
              wrEn         = 1'b1;
              nxt_ptr      = ptr_ff + 8'h01;
              nxt_busState = BUS_ACK_DATA;
            end
          end
        end
        BUS_ACK_ADDR, BUS_ACK_REG, BUS_ACK_DATA: begin
          if (sclFall) begin
            nxt_sdaOe = 1'b0;
            if (busState_ff == BUS_ACK_ADDR && rwBit_ff) begin
              nxt_shift    = rdData;
              nxt_sdaOe    = ~rdData[7];
              nxt_bitCnt   = 4'h1;
              nxt_busState = BUS_RDATA;
            end else if (busState_ff == BUS_ACK_ADDR) begin
              nxt_busState = BUS_WREG;
            end else begin
              nxt_busState = BUS_WDATA;
            end
          end
        end
        BUS_RDATA: begin
          if (sclFall) begin
            if (bitCnt_ff == 4'h8) begin
              // pointer advances after each read byte
              nxt_sdaOe    = 1'b0;
              nxt_ptr      = ptr_ff + 8'h01;
              nxt_busState = BUS_RACK;
            end else begin
              nxt_shift  = {shift_ff[6:0], 1'b0};
              nxt_sdaOe  = ~shift_ff[6];
              nxt_bitCnt = bitCnt_ff + 4'h1;
            end
          end
        end
        BUS_RACK: begin
          if (sclRise && sdaF_ff) begin
            nxt_busState = BUS_IDLE;
          end else if (sclFall) begin
            nxt_shift    = rdData;
            nxt_sdaOe    = ~rdData[7];
            nxt_bitCnt   = 4'h1;
            nxt_busState = BUS_RDATA;
          end
        end
        default: begin
          nxt_busState = BUS_IDLE;
        end
      endcase
    end
  end

  // the bus slave survives a soft reset so the write that caused it still gets its ack
  always_ff @(posedge core_clk or posedge rstAll) begin
    if (rstAll) begin
      busState_ff <= BUS_IDLE;
      bitCnt_ff   <= 4'h0;
      shift_ff    <= 8'h00;
      ptr_ff      <= 8'h00;
      rwBit_ff    <= 1'b0;
      sdaOe_ff    <= 1'b0;
    end else begin
      busState_ff <= nxt_busState;
      bitCnt_ff   <= nxt_bitCnt;
      shift_ff    <= nxt_shift;
      ptr_ff      <= nxt_ptr;
      rwBit_ff    <= nxt_rwBit;
      sdaOe_ff    <= nxt_sdaOe;
    end
  end

  // decoded write strobes for the reset bits
  // soft reset decode
  assign softRst = wrEn && page_ff == PAGE_CTRL && ptr_ff == SOFT_RST_OFF
                   && shift_ff[SOFT_RST_BIT];

  always_comb begin
    stageRst = '0;
    if (wrEn && page_ff == PAGE_OUT && ptr_ff == HP_RST_OFF) begin
      stageRst[0] = shift_ff[LEFT_RST_BIT];
      stageRst[1] = shift_ff[RIGHT_RST_BIT];
    end
    if (wrEn && page_ff == PAGE_OUT && ptr_ff == SPK_RST_OFF) begin
      stageRst[2] = shift_ff[LEFT_RST_BIT];
      stageRst[3] = shift_ff[RIGHT_RST_BIT];
    end
  end

  // control next state: page, power, lockout timer, pll timer
  always_comb begin
    nxt_page     = page_ff;
    nxt_power    = power_ff;
    nxt_initCnt  = initCnt_ff;
    nxt_initBusy = initBusy_ff;
    nxt_pllCnt   = pllCnt_ff;
    nxt_clkReady = clkReady_ff;
    if (wrEn && ptr_ff == PAGE_SEL_OFF) begin
      nxt_page = shift_ff;
    end
    if (wrEn && page_ff == PAGE_CTRL && ptr_ff == POWER_CTRL_OFF && !initBusy_ff) begin
      nxt_power = shift_ff;
    end
    if (initBusy_ff) begin
      if (initCnt_ff == INIT_LAST) begin
        nxt_initBusy = 1'b0;
      end else begin
        nxt_initCnt = initCnt_ff + 1'b1;
      end
    end
    // codec clocks held off while the pll settles
    if (!power_ff[PLL_PWR_BIT]) begin
      nxt_pllCnt   = '0;
      nxt_clkReady = 1'b0;
    end else if (!clkReady_ff) begin
      if (pllCnt_ff == PLL_LAST) begin
        nxt_clkReady = 1'b1;
      end else begin
        nxt_pllCnt = pllCnt_ff + 1'b1;
      end
    end
    // soft reset returns control state to defaults and restarts lockout
    if (softRst) begin
      nxt_page     = PAGE_RST;
      nxt_power    = POWER_CTRL_RST;
      nxt_initCnt  = '0;
      nxt_initBusy = 1'b1;
      nxt_pllCnt   = '0;
      nxt_clkReady = 1'b0;
    end
  end

  // per-stage latch and enable; a fault in the same cycle as its reset wins
  genvar gs;
  generate
    for (gs = 0; gs < NUM_STAGES; gs++) begin : g_stage
      assign nxt_latched[gs] = overcurrent[gs] | (latched_ff[gs] & ~stageRst[gs] & ~softRst);
      // stage runs only when written on and lockout over
      assign nxt_stageEn[gs] = power_ff[gs] & ~latched_ff[gs] & ~initBusy_ff;
    end
  endgenerate

  // everything powered down after reset; power bits never touch other settings
  always_ff @(posedge core_clk or posedge rstAll) begin
    if (rstAll) begin
      page_ff     <= PAGE_RST;
      power_ff    <= POWER_CTRL_RST;
      initCnt_ff  <= '0;
      initBusy_ff <= 1'b1;
      pllCnt_ff   <= '0;
      clkReady_ff <= 1'b0;
      latched_ff  <= '0;
      stageEn_ff  <= '0;
    end else begin
      page_ff     <= nxt_page;
      power_ff    <= nxt_power;
      initCnt_ff  <= nxt_initCnt;
      initBusy_ff <= nxt_initBusy;
      pllCnt_ff   <= nxt_pllCnt;
      clkReady_ff <= nxt_clkReady;
      latched_ff  <= nxt_latched;
      stageEn_ff  <= nxt_stageEn;
    end
  end

  // coefficient buffer; contents are not cleared by reset, only accesses are gated
  // writes ignored during lockout
  always_ff @(posedge core_clk) begin
    if (wrEn && coefOk) begin
      coefMem_ff[ptr_ff[$clog2(COEF_DEPTH)-1:0]] <= shift_ff;
    end
  end

  // outputs straight from flops except sdaOut, tied low; the data pin only ever pulls low
  assign sdaOut         = 1'b0;
  assign sdaOe          = sdaOe_ff;
  assign stageEnable    = stageEn_ff;
  assign pllPowerOn     = power_ff[PLL_PWR_BIT];
  assign codecClkEnable = clkReady_ff;
  assign initBusy       = initBusy_ff;

endmodule
`default_nettype wire

// file: crpc_pkg.sv
// constants, register map and bus states of the codec reset and power control block
package crpc_pkg;

  // control bus slave address, seven bits
  localparam logic [6:0] SLAVE_ADDR     = 7'h18;

  // pages
  localparam logic [7:0] PAGE_CTRL      = 8'h00;
  localparam logic [7:0] PAGE_OUT       = 8'h01;
  localparam logic [7:0] PAGE_COEF      = 8'h08;

  // register offsets
  localparam logic [7:0] PAGE_SEL_OFF   = 8'h00;
  localparam logic [7:0] SOFT_RST_OFF   = 8'h01;
  localparam logic [7:0] STATUS_OFF     = 8'h02;
  localparam logic [7:0] POWER_CTRL_OFF = 8'h03;
  localparam logic [7:0] HP_RST_OFF     = 8'h1f;
  localparam logic [7:0] SPK_RST_OFF    = 8'h20;

  // field positions
  localparam int SOFT_RST_BIT   = 0;
  localparam int LEFT_RST_BIT   = 7;
  localparam int RIGHT_RST_BIT  = 6;
  localparam int PLL_PWR_BIT    = 7;
  localparam int STAT_CLK_BIT   = 7;
  localparam int STAT_INIT_BIT  = 6;

  // values after reset
  localparam logic [7:0] PAGE_RST       = 8'h00;
  localparam logic [7:0] POWER_CTRL_RST = 8'h00;

  // output stages: 0 left headphone, 1 right headphone, 2 left speaker, 3 right speaker
  localparam int NUM_STAGES = 4;

  // timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int INIT_TIME_NS  = 1000000;
  localparam int PLL_TIME_NS   = 10000000;
  // initialization must finish within the limit: round down
  localparam int INIT_CYCLES   = INIT_TIME_NS / CLK_PERIOD_NS;
  // pll settle is a least time: round up
  localparam int PLL_CYCLES    = (PLL_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W         = 24;

  // control bus slave states
  typedef enum logic [3:0] {
    BUS_IDLE, BUS_ADDR, BUS_ACK_ADDR, BUS_WREG, BUS_ACK_REG,
    BUS_WDATA, BUS_ACK_DATA, BUS_RDATA, BUS_RACK
  } crpc_bus_state_t;

endpackage

// file: crpc_props.sv
// port checker for lockout, pll settle, stage cut-off and reset behaviour
`timescale 1ns/1ps
`default_nettype none
module crpc_props #(
  parameter int INIT_COUNT = 20,
  parameter int PLL_COUNT  = 30,
  parameter int COEF_DEPTH = 16
) (
  // clock and resets
  input wire logic                            core_clk,
  input wire logic                            reset,
  input wire logic                            resetPinN,
  // bus pins
  input wire logic                            scl,
  input wire logic                            sdaIn,
  input wire logic                            sdaOut,
  input wire logic                            sdaOe,
  // stages and status
  input wire logic [crpc_pkg::NUM_STAGES-1:0] overcurrent,
  input wire logic [crpc_pkg::NUM_STAGES-1:0] stageEnable,
  input wire logic                            pllPowerOn,
  input wire logic                            codecClkEnable,
  input wire logic                            initBusy
);
  import crpc_pkg::*;
  logic        rstAny;
  logic [23:0] busyCnt_ff, nxt_busyCnt, pllCnt_ff, nxt_pllCnt;
  assign rstAny = reset || !resetPinN;
  // run lengths of lockout and pll power, cleared when the level drops
  always_comb begin
    nxt_busyCnt = initBusy ? busyCnt_ff + 24'h00_0001 : 24'h00_0000;
    nxt_pllCnt  = pllPowerOn ? pllCnt_ff + 24'h00_0001 : 24'h00_0000;
  end
  // either reset source clears the run lengths at once
  always_ff @(posedge core_clk or posedge rstAny) begin
    if (rstAny) begin
      busyCnt_ff <= 24'h00_0000;
      pllCnt_ff  <= 24'h00_0000;
    end else begin
      busyCnt_ff <= nxt_busyCnt;
      pllCnt_ff  <= nxt_pllCnt;
    end
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (rstAny);
  sequence busyEnds;
    $fell(initBusy);
  endsequence
  sequence clkUp;
    $rose(codecClkEnable);
  endsequence
  sda_open_drain_a: assert property (sdaOut == 1'b0)
    else $error("data drive value not low");
  oe_scl_low_a: assert property ($changed(sdaOe) |-> !scl)
    else $error("data drive changed while clock high");
  pin_reset_a: assert property (disable iff (reset) !resetPinN |->
    initBusy && !pllPowerOn && !codecClkEnable && stageEnable == '0 && !sdaOe)
    else $error("pin reset left outputs active");
  busy_bound_a: assert property (initBusy |-> busyCnt_ff <= INIT_COUNT + 1)
    else $error("lockout too long");
  busy_len_a: assert property (busyEnds |-> busyCnt_ff >= INIT_COUNT - 1)
    else $error("lockout too short");
  lock_power_a: assert property (initBusy && $past(initBusy) |->
    !pllPowerOn && stageEnable == '0)
    else $error("block powered during lockout");
  pll_wait_a: assert property (clkUp |->
    pllCnt_ff >= PLL_COUNT - 1 && pllCnt_ff <= PLL_COUNT + 2)
    else $error("codec clock settle time wrong");
  clk_drop_a: assert property (!pllPowerOn |=> !codecClkEnable)
    else $error("codec clock without pll");
  oc_cut_a: assert property (|overcurrent |->
    ##2 ((stageEnable & $past(overcurrent, 2)) == '0))
    else $error("stage still on after overcurrent");
endmodule
bind crpc_codec_reset_power_control crpc_props #(.INIT_COUNT(INIT_COUNT), .PLL_COUNT(PLL_COUNT),
  .COEF_DEPTH(COEF_DEPTH)) props_u (.core_clk(core_clk), .reset(reset), .resetPinN(resetPinN),
  .scl(scl), .sdaIn(sdaIn), .sdaOut(sdaOut), .sdaOe(sdaOe), .overcurrent(overcurrent),
  .stageEnable(stageEnable), .pllPowerOn(pllPowerOn), .codecClkEnable(codecClkEnable),
  .initBusy(initBusy));
`default_nettype wire

// file: crpc_host_model.sv
// host bus master model: drives the clock line and pulls the data line low
`timescale 1ns/1ps
`default_nettype none
module crpc_host_model (
  // clock and device drive
  input wire logic core_clk,
  input wire logic sdaOe,
  input wire logic sdaOut,
  // bus lines
  output logic     scl,
  output logic     sdaLine
);
  logic hostLow = 1'b0;
  // pulled-up line: low when either side pulls it
  assign sdaLine = !(hostLow || (sdaOe && !sdaOut));
  initial scl = 1'b1;
  // quarter bit of 4 clocks: faster than fast mode to keep the run short
  task automatic wt();
    repeat (4) @(posedge core_clk);
    #1;
  endtask
  // data set mid-low, sampled mid-high
  task automatic bitIo(input logic b, output logic s);
    wt();
    hostLow = !b;
    wt();
    scl = 1'b1;
    wt();
    s = sdaLine;
    wt();
    scl = 1'b0;
  endtask
  task automatic start();
    wt();
    hostLow = 1'b0;
    wt();
    scl = 1'b1;
    wt();
    hostLow = 1'b1;
    wt();
    scl = 1'b0;
  endtask
  task automatic stop();
    wt();
    hostLow = 1'b1;
    wt();
    scl = 1'b1;
    wt();
    hostLow = 1'b0;
  endtask
  task automatic sendByte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) bitIo(b[i], s);
    bitIo(1'b1, s);
    ack = !s;
  endtask
  task automatic recvByte(output logic [7:0] b, input logic last);
    logic s;
    for (int i = 7; i >= 0; i--) bitIo(1'b1, b[i]);
    bitIo(last, s);
  endtask
endmodule
`default_nettype wire

// file: crpc_tb.sv
// bench: register traffic, lockout, pll wait, stage resets, soft and pin reset
`timescale 1ns/1ps
`default_nettype none
module tb;
  import crpc_pkg::*;
  localparam int INIT_N = 4000;
  localparam int PLL_N  = 200;
  localparam int LIMIT  = 60000;
  logic                  core_clk, reset, resetPinN, scl, sdaLine, sdaOut, sdaOe, ack;
  logic                  pllPowerOn, codecClkEnable, initBusy;
  logic [NUM_STAGES-1:0] overcurrent, stageEnable;
  logic [15:0]           rd;
  int                    mismatches = 0, check_count = 0, cycles = 0;
  crpc_codec_reset_power_control #(.INIT_COUNT(INIT_N), .PLL_COUNT(PLL_N), .COEF_DEPTH(16))
    dut_u (
    .core_clk(core_clk), .reset(reset), .resetPinN(resetPinN), .scl(scl), .sdaIn(sdaLine),
    .sdaOut(sdaOut), .sdaOe(sdaOe), .overcurrent(overcurrent), .stageEnable(stageEnable),
    .pllPowerOn(pllPowerOn), .codecClkEnable(codecClkEnable), .initBusy(initBusy));
  crpc_host_model host_u (.core_clk(core_clk), .sdaOe(sdaOe), .sdaOut(sdaOut), .scl(scl),
    .sdaLine(sdaLine));
  // clock and hang guard
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == LIMIT) begin
      mismatches++;
      wrap_up();
    end
  end
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // status outputs packed as pll, clock, busy, 0, stages
  function automatic logic [15:0] outs();
    return {8'h00, pllPowerOn, codecClkEnable, initBusy, 1'b0, stageEnable};
  endfunction
  task automatic addr(input logic rw);
    host_u.start();
    host_u.sendByte({SLAVE_ADDR, rw}, ack);
    check(ack, 1'b1);
  endtask
  task automatic wrReg(input logic [7:0] ptr, input logic [7:0] d);
    addr(1'b0);
    host_u.sendByte(ptr, ack);
    host_u.sendByte(d, ack);
    host_u.stop();
  endtask
  task automatic wrPair(input logic [7:0] ptr, input logic [15:0] d);
    addr(1'b0);
    host_u.sendByte(ptr, ack);
    host_u.sendByte(d[15:8], ack);
    host_u.sendByte(d[7:0], ack);
    host_u.stop();
  endtask
  task automatic rdPair(input logic [7:0] ptr, output logic [15:0] v);
    addr(1'b0);
    host_u.sendByte(ptr, ack);
    addr(1'b1);
    host_u.recvByte(v[15:8], 1'b0);
    host_u.recvByte(v[7:0], 1'b1);
    host_u.stop();
  endtask
  task automatic waitIdle();
    for (int i = 0; i < INIT_N + 100 && initBusy !== 1'b0; i++) @(posedge core_clk);
    #1;
    check(initBusy, 1'b0);
  endtask
  // main sequence
  initial begin
    reset = 1'b1;
    resetPinN = 1'b0;
    overcurrent = 4'h0;
    repeat (4) @(posedge core_clk);
    #1;
    reset = 1'b0;
    resetPinN = 1'b1;
    check(outs(), 16'h0020);
    rdPair(STATUS_OFF, rd);
    check(rd, 16'h4000);
    wrReg(POWER_CTRL_OFF, 8'h8F);
    check(outs(), 16'h0020);
    waitIdle();
    rdPair(POWER_CTRL_OFF, rd);
    check(rd[15:8], 8'h00);
    host_u.start();
    host_u.sendByte({SLAVE_ADDR ^ 7'h01, 1'b0}, ack);
    host_u.stop();
    check(ack, 1'b0);
    wrReg(POWER_CTRL_OFF, 8'h8F);
    check(outs(), 16'h008F);
    rdPair(POWER_CTRL_OFF, rd);
    check(rd[15:8], 8'h8F);
    check(codecClkEnable, 1'b1);
    @(posedge core_clk);
    #1;
    overcurrent = 4'hF;
    @(posedge core_clk);
    #1;
    overcurrent = 4'h0;
    repeat (3) @(posedge core_clk);
    #1;
    check(outs(), 16'h00C0);
    rdPair(STATUS_OFF, rd);
    check(rd, 16'h8F8F);
    wrReg(PAGE_SEL_OFF, PAGE_OUT);
    for (int i = 0; i < NUM_STAGES; i++) begin
      wrReg(i < 2 ? HP_RST_OFF : SPK_RST_OFF, i[0] ? 8'h40 : 8'h80);
      check(outs(), 16'h00C0 | 16'((2 << i) - 1));
    end
    rdPair(HP_RST_OFF, rd);
    check(rd, 16'h0000);
    wrReg(PAGE_SEL_OFF, PAGE_COEF);
    wrPair(8'h01, 16'h5AC3);
    rdPair(8'h01, rd);
    check(rd, 16'h5AC3);
    wrReg(PAGE_SEL_OFF, PAGE_CTRL);
    wrReg(POWER_CTRL_OFF, 8'h00);
    check(outs(), 16'h0000);
    wrReg(PAGE_SEL_OFF, PAGE_COEF);
    rdPair(8'h01, rd);
    check(rd, 16'h5AC3);
    wrReg(PAGE_SEL_OFF, PAGE_CTRL);
    wrReg(POWER_CTRL_OFF, 8'h8F);
    wrReg(SOFT_RST_OFF, 8'h01);
    check(outs(), 16'h0020);
    rdPair(SOFT_RST_OFF, rd);
    check(rd, 16'h0040);
    wrReg(PAGE_SEL_OFF, PAGE_COEF);
    wrReg(8'h01, 8'hFF);
    rdPair(8'h01, rd);
    check(rd, 16'h0000);
    waitIdle();
    rdPair(8'h01, rd);
    check(rd, 16'h5AC3);
    @(posedge core_clk);
    #1;
    resetPinN = 1'b0;
    #10;
    resetPinN = 1'b1;
    #1;
    check(outs(), 16'h0020);
    rdPair(PAGE_SEL_OFF, rd);
    check(rd[15:8], 8'h00);
    wrap_up();
  end
endmodule
`default_nettype wire
